/* rtl/tqp_timer.sv */
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Wrap past FFFF sets overflow flag
// - Bit clear or byte write bit0=0 clears
// - Overflow coinciding with clear keeps flag set
// - Counter read buffer returns live count
// - Capture edge stores count per channel
// - Mode field 111 selects triangular PWM
// - CCR0 sets cycle, CCR1-3 set duty
// - Compare rewrites allowed while enabled
// - Clearing enable bit stops timer
// - Ch0 toggles at match and underflow
// - PWM modes: compare only, no capture
// - Ch0 square wave per mode table
// - Output level and enable truth table
// - Slave sync enable bit selects tuning
// - Master compares pass on write or match, except in triangle mode
module tqp_timer (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [3:0] CAPTURE_INPUT_PIN_IN,
    input wire logic [1:0] MASTER_XFER_MODE_IN,
    input wire logic MASTER_CPU_WR_IN,
    input wire logic MASTER_MATCH_IN,
    input wire logic [63:0] MASTER_CCR_IN,
    output logic [3:0] TIMER_OUTPUT_OUT
);
    logic [7:0] control_register_0_ff;
    logic [7:0] control_register_1_ff;
    logic [7:0] output_control_register_ff;
    logic [3:0] capture_compare_select_ff;
    logic overflow_flag_ff;
    logic [15:0] cnt_ff;
    logic down_ff;
    logic [15:0] ccr_ff [4];
    logic [3:0] out_ff;
    logic [3:0] run_ff;
    logic [31:0] prdata_ff;
    logic [3:0] rise;
    logic tick;
    logic wr;
    logic ce;
    logic sye;
    logic [2:0] mode;
    logic tri_mode;
    logic pwm_mode;
    logic wrap;
    logic underflow;
    logic match0;
    logic bit_clr;
    logic byte_clr;
    logic mapped;
    logic sync_load;

    assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign ce = control_register_0_ff[tqp_pkg::CE_BIT];
    assign sye = control_register_1_ff[tqp_pkg::SYE_BIT];
    assign mode = control_register_1_ff[2:0];
    assign tri_mode = (mode == tqp_pkg::MD_TRIPWM);
    assign pwm_mode = tri_mode || (mode == tqp_pkg::MD_PWM);
    assign mapped = (PADDR_IN <= tqp_pkg::OFS_OVFCLR) && (PADDR_IN[1:0] == 2'h0);
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
    assign PRDATA_OUT = prdata_ff;

    tqp_count_div u_div (
        .CLK_IN(CLK_IN),
        .NRST_IN(NRST_IN),
        .RUN_IN(ce),
        .TICK_OUT(tick)
    );

    tqp_edge_det u_edge (
        .CLK_IN(CLK_IN),
        .NRST_IN(NRST_IN),
        .SIG_IN(CAPTURE_INPUT_PIN_IN),
        .RISE_OUT(rise)
    );

    // Counter events on the count tick
    assign wrap = tick && !tri_mode && (cnt_ff == tqp_pkg::CNT_MAX);
    assign match0 = tick && (cnt_ff == ccr_ff[0]);
    assign underflow = tick && tri_mode && down_ff && (cnt_ff == 16'h0001);

    // Counter: stop clears it; triangle folds at CCR0 and at zero
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cnt_ff <= tqp_pkg::CCR_RST;
            down_ff <= 1'b0;
        end else if (!ce) begin
            cnt_ff <= tqp_pkg::CCR_RST;
            down_ff <= 1'b0;
        end else if (tick && tri_mode) begin
            if (!down_ff && cnt_ff >= ccr_ff[0]) begin
                down_ff <= 1'b1;
                cnt_ff <= cnt_ff - 16'h0001;
            end else if (down_ff && cnt_ff == 16'h0000) begin
                down_ff <= 1'b0;
                cnt_ff <= 16'h0001;
            end else if (down_ff) begin
                cnt_ff <= cnt_ff - 16'h0001;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001; // Wraps to 0000 after FFFF
        end
    end

    // Overflow flag: set beats either clear form
    assign bit_clr = wr && (PADDR_IN == tqp_pkg::OFS_OVFCLR) && PWDATA_IN[tqp_pkg::OVF_BIT];
    assign byte_clr = wr && (PADDR_IN == tqp_pkg::OFS_OPT0) && !PWDATA_IN[tqp_pkg::OVF_BIT];
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            overflow_flag_ff <= 1'b0;
        end else if (wrap) begin
            overflow_flag_ff <= 1'b1;
        end else if (bit_clr || byte_clr) begin
            overflow_flag_ff <= 1'b0;
        end
    end

    // Control registers; bit 0 of option is the flag, handled above
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            control_register_0_ff <= tqp_pkg::CTL_RST;
            control_register_1_ff <= tqp_pkg::CTL_RST;
            output_control_register_ff <= tqp_pkg::CTL_RST;
            capture_compare_select_ff <= 4'h0;
        end else if (wr) begin
            unique case (PADDR_IN)
                tqp_pkg::OFS_CTL0: control_register_0_ff <= PWDATA_IN[7:0];
                tqp_pkg::OFS_CTL1: control_register_1_ff <= PWDATA_IN[7:0];
                tqp_pkg::OFS_IOC0: output_control_register_ff <= PWDATA_IN[7:0];
                tqp_pkg::OFS_OPT0: capture_compare_select_ff <= PWDATA_IN[tqp_pkg::CCS_LSB +: 4];
                default: ;
            endcase
        end
    end

    // Slave load from master outside triangle mode: CPU write in pulse-generator mode, master match in match mode
    assign sync_load = sye && !tri_mode &&
        ((MASTER_XFER_MODE_IN == tqp_pkg::XFER_PULSE_GEN) ? MASTER_CPU_WR_IN
        : (MASTER_XFER_MODE_IN == tqp_pkg::XFER_MATCH) && MASTER_MATCH_IN);

    // Capture/compare registers: writes any time unless a master load or capture lands that cycle, capture outside PWM
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ccr
            always_ff @(posedge CLK_IN or negedge NRST_IN) begin
                if (!NRST_IN) begin
                    ccr_ff[g] <= tqp_pkg::CCR_RST;
                end else if (sync_load) begin
                    ccr_ff[g] <= MASTER_CCR_IN[16*g +: 16];
                end else if (ce && !pwm_mode && capture_compare_select_ff[g] && rise[g]) begin
                    ccr_ff[g] <= cnt_ff;
                end else if (wr && PADDR_IN == tqp_pkg::OFS_CCR0 + 8'(4 * g)) begin
                    ccr_ff[g] <= PWDATA_IN[15:0];
                end
            end
        end
    endgenerate

    // Output waveforms before the pin mux
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            out_ff <= 4'h0;
        end else if (!ce) begin
            out_ff <= 4'h0; // Idle phase so start gives a clean edge
        end else if (tri_mode) begin
            if (match0 || underflow) begin
                out_ff[0] <= ~out_ff[0];
            end
            for (int k = 1; k < 4; k++) begin
                if (tick && cnt_ff == ccr_ff[k]) begin
                    out_ff[k] <= ~down_ff;
                end
            end
        end else if (mode != tqp_pkg::MD_PULSEW && match0) begin
            // Other modes except pulse-width toggle only on compare match, as a square wave
            out_ff[0] <= ~out_ff[0];
        end
    end

    // Tracks whether each channel has started counting
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            run_ff <= 4'h0;
        end else begin
            run_ff <= {4{ce}};
        end
    end

    // Pin: level bit when disabled, stopped or in pulse-width mode; inverted once counting runs on ch0, and on ch1-3 in triangle mode
    // Enable gates at once, so a stop restores the level without a stray cycle
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            logic oe;
            logic ol;
            assign oe = output_control_register_ff[tqp_pkg::OE_LSB + g];
            assign ol = output_control_register_ff[tqp_pkg::OL_LSB + g];
            assign TIMER_OUTPUT_OUT[g] = ol ^ (oe && ce && run_ff[g] &&
                (g == 0 || tri_mode) && mode != tqp_pkg::MD_PULSEW &&
                ~out_ff[g]);
        end
    endgenerate

    // Read data registered in setup phase
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            prdata_ff <= 32'h00000000;
        end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            unique case (PADDR_IN)
                tqp_pkg::OFS_CTL0: prdata_ff <= {24'h000000, control_register_0_ff};
                tqp_pkg::OFS_CTL1: prdata_ff <= {24'h000000, control_register_1_ff};
                tqp_pkg::OFS_IOC0: prdata_ff <= {24'h000000, output_control_register_ff};
                tqp_pkg::OFS_OPT0:
                    prdata_ff <= {24'h000000, capture_compare_select_ff, 3'h0, overflow_flag_ff};
                tqp_pkg::OFS_CNT: prdata_ff <= {16'h0000, cnt_ff};
                tqp_pkg::OFS_CCR0: prdata_ff <= {16'h0000, ccr_ff[0]};
                tqp_pkg::OFS_CCR0 + 8'h04: prdata_ff <= {16'h0000, ccr_ff[1]};
                tqp_pkg::OFS_CCR0 + 8'h08: prdata_ff <= {16'h0000, ccr_ff[2]};
                tqp_pkg::OFS_CCR0 + 8'h0C: prdata_ff <= {16'h0000, ccr_ff[3]};
                default: prdata_ff <= 32'h00000000;
            endcase
        end
    end
endmodule // tqp_timer

/* rtl/tqp_pkg.sv */
package tqp_pkg;
    // Register byte offsets (chosen; word aligned)
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_IOC0 = 8'h08;
    localparam logic [7:0] OFS_OPT0 = 8'h0C;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_CCR0 = 8'h14;
    localparam logic [7:0] OFS_OVFCLR = 8'h24;
    // Field positions
    localparam int CE_BIT = 7;
    localparam int SYE_BIT = 5;
    localparam int OVF_BIT = 0;
    localparam int CCS_LSB = 4;
    localparam int OE_LSB = 0;
    localparam int OL_LSB = 4;
    // Mode field codes
    localparam logic [2:0] MD_INTERVAL = 3'h0;
    localparam logic [2:0] MD_EXTEVT = 3'h1;
    localparam logic [2:0] MD_EXTTRG = 3'h2;
    localparam logic [2:0] MD_ONESHOT = 3'h3;
    localparam logic [2:0] MD_PWM = 3'h4;
    localparam logic [2:0] MD_FREERUN = 3'h5;
    localparam logic [2:0] MD_PULSEW = 3'h6;
    localparam logic [2:0] MD_TRIPWM = 3'h7;
    // Reset values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [15:0] CCR_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Count clock divider: one enable pulse every CNT_DIV clocks
    localparam logic [7:0] CNT_DIV = 8'h01;
    // Master compare transfer sources
    localparam logic [1:0] XFER_PULSE_GEN = 2'h0;
    localparam logic [1:0] XFER_MATCH = 2'h1;
endpackage

/* rtl/tqp_edge_det.sv */
`timescale 1ns/1ps
// Rising-edge detector on the capture inputs, one per channel
module tqp_edge_det (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] SIG_IN,
    output logic [3:0] RISE_OUT
);
    logic [3:0] prev_ff;

    // Previous sample; inputs are already synchronous
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            prev_ff <= 4'h0;
        end else begin
            prev_ff <= SIG_IN;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_edge
            assign RISE_OUT[g] = SIG_IN[g] & ~prev_ff[g];
        end
    endgenerate
endmodule // tqp_edge_det

/* rtl/tqp_count_div.sv */
`timescale 1ns/1ps
// Count clock enable divider
module tqp_count_div (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic RUN_IN,
    output logic TICK_OUT
);
    logic [7:0] cnt_ff;

    // Restart on stop so first tick is a full period away
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cnt_ff <= 8'h00;
        end else if (!RUN_IN || cnt_ff == tqp_pkg::CNT_DIV - 8'h01) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    assign TICK_OUT = RUN_IN && (cnt_ff == tqp_pkg::CNT_DIV - 8'h01);
endmodule // tqp_count_div

/* dv/tqp_chk_props.sv */
`timescale 1ns/1ps
// Port-level checker: shadows enable and pin control from APB writes
module tqp_chk (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [3:0] TIMER_OUTPUT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    logic [7:0] ioc_ff;
    logic ce_ff;
    logic [1:0] idle_ff;
    wire acc = PSEL_IN && PENABLE_IN;
    wire wr = acc && PWRITE_IN && PREADY_OUT;
    wire bad = (PADDR_IN[1:0] != 2'h0) || (PADDR_IN > 8'h24);
    // Shadow copies, updated at the same edge the write lands
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ioc_ff <= 8'h00;
            ce_ff <= 1'h0;
        end else if (wr && PADDR_IN == 8'h08) begin
            ioc_ff <= PWDATA_IN[7:0];
        end else if (wr && PADDR_IN == 8'h00) begin
            ce_ff <= PWDATA_IN[7];
        end
    end
    // Stopped-time counter; the read latch lags the clear by an edge
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            idle_ff <= 2'h0;
        end else begin
            idle_ff <= ce_ff ? 2'h0 : (idle_ff == 2'h3 ? idle_ff : idle_ff + 2'h1);
        end
    end
    chk_ready_high: assert property (PREADY_OUT)
        else $error("ready dropped");
    chk_err_bad_addr: assert property (acc && bad |-> PSLVERR_OUT)
        else $error("no error on unmapped address");
    chk_err_mapped_ok: assert property (acc && !bad |-> !PSLVERR_OUT)
        else $error("error on mapped address");
    chk_err_only_access: assert property (PSLVERR_OUT |-> acc ##1 !PSLVERR_OUT)
        else $error("error outside access phase");
    chk_err_read_zero: assert property (acc && bad && !PWRITE_IN |-> PRDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (acc && !PWRITE_IN |-> PRDATA_OUT[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_pin_level: assert property (((TIMER_OUTPUT_OUT ^ ioc_ff[7:4]) & ~ioc_ff[3:0]) == 4'h0)
        else $error("disabled pin not at level");
    chk_pin_stopped: assert property (!ce_ff |-> TIMER_OUTPUT_OUT == ioc_ff[7:4])
        else $error("stopped pin not at level");
    chk_cnt_cleared: assert property (acc && !PWRITE_IN && PADDR_IN == 8'h10 && idle_ff == 2'h3
        |-> PRDATA_OUT == 32'h0)
        else $error("counter runs while stopped");
endmodule // tqp_chk

/* dv/tqp_master_model.sv */
`timescale 1ns/1ps
// Master timer stand-in: never in triangle mode, free-running or PWM only
module tqp_master_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic go_in,
    input wire logic match_mode_in,
    input wire logic [15:0] base_in,
    output logic [1:0] xfer_mode_out,
    output logic cpu_wr_out,
    output logic match_out,
    output logic [63:0] ccr_out
);
    // Compares held steady by the bench around each strobe
    assign ccr_out = {base_in + 16'h3, base_in + 16'h2, base_in + 16'h1, base_in};
    assign xfer_mode_out = match_mode_in ? tqp_pkg::XFER_MATCH : tqp_pkg::XFER_PULSE_GEN;
    // One-cycle strobe, started only after the slave is set up
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpu_wr_out <= 1'h0;
            match_out <= 1'h0;
        end else begin
            cpu_wr_out <= go_in && !match_mode_in;
            match_out <= go_in && match_mode_in;
        end
    end
endmodule // tqp_master_model

/* dv/tqp_timer_bench.sv */
`timescale 1ns/1ps
module tqp_timer_bench;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, err, go, mm, cwr, mt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, a;
    logic [3:0] cap, pins;
    logic [15:0] base;
    logic [1:0] xm;
    logic [63:0] ccr;
    int n_fail, n_checks, e0, e1, n;
    tqp_timer tqp_timer_i (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .CAPTURE_INPUT_PIN_IN(cap), .MASTER_XFER_MODE_IN(xm), .MASTER_CPU_WR_IN(cwr),
        .MASTER_MATCH_IN(mt), .MASTER_CCR_IN(ccr), .TIMER_OUTPUT_OUT(pins));
    tqp_master_model tqp_master_model_i (.clk_in(clk), .nrst_in(nrst), .go_in(go),
        .match_mode_in(mm), .base_in(base), .xfer_mode_out(xm), .cpu_wr_out(cwr),
        .match_out(mt), .ccr_out(ccr));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // One APB transfer; holds everything until pready is seen
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Strobe the master model once with fresh compares
    task automatic sync(input logic m, input logic [15:0] b);
        @(posedge clk);
        mm <= m;
        base <= b;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // Hang guard, sized above one full counter wrap
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        final_report();
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, cap, go, mm, base} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        for (int i = 0; i < 9; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            check(q, 32'h0);
        end
        apb(1'h0, 8'h28, 32'h0);
        check(q, 32'h0);
        check(err, 1'h1);
        apb(1'h1, 8'h08, 32'hA0);
        @(negedge clk);
        check(pins, 4'hA);
        apb(1'h1, 8'h08, 32'h5F);
        @(negedge clk);
        check(pins, 4'h5);
        // Triangle: cycle 8, duties inside it, capture armed
        apb(1'h1, 8'h0C, 32'hF0);
        apb(1'h1, 8'h04, 32'h07);
        apb(1'h1, 8'h14, 32'h08);
        apb(1'h1, 8'h18, 32'h04);
        apb(1'h1, 8'h00, 32'h80);
        e0 = 0;
        e1 = 0;
        a = pins;
        repeat (160) begin
            @(negedge clk);
            e0 += int'(pins[0] != a[0]);
            e1 += int'(pins[1] != a[1]);
            a = pins;
        end
        // Start inversion, then two changes per 16-tick triangle period
        check(e0, 20);
        check(e1, 21);
        apb(1'h1, 8'h18, 32'h05);
        cap <= 4'h2;
        apb(1'h0, 8'h18, 32'h0);
        cap <= 4'h0;
        check(q, 32'h05);
        apb(1'h1, 8'h00, 32'h00);
        @(negedge clk);
        check(pins, 4'h5);
        // Free-running: live count, capture, overflow
        apb(1'h1, 8'h04, 32'h05);
        apb(1'h1, 8'h00, 32'h80);
        apb(1'h0, 8'h10, 32'h0);
        a = q;
        apb(1'h0, 8'h10, 32'h0);
        check(q - a, 32'h3);
        cap <= 4'h4;
        apb(1'h0, 8'h1C, 32'h0);
        cap <= 4'h0;
        check(q > a && q < a + 32'h10, 1);
        n = 0;
        do apb(1'h0, 8'h0C, 32'h0); while (q[0] !== 1'h1 && n++ < 30000);
        check(q, 32'hF1);
        apb(1'h1, 8'h24, 32'h01);
        apb(1'h0, 8'h0C, 32'h0);
        check(q, 32'hF0);
        // Tuned slave: transfer on write, then on match
        apb(1'h1, 8'h00, 32'h00);
        apb(1'h1, 8'h04, 32'h25);
        apb(1'h1, 8'h00, 32'h80);
        sync(1'h0, 16'h1230);
        apb(1'h0, 8'h20, 32'h0);
        check(q, 32'h1233);
        sync(1'h1, 16'h4560);
        apb(1'h0, 8'h18, 32'h0);
        check(q, 32'h4561);
        final_report();
    end
endmodule // tqp_timer_bench
bind tqp_timer tqp_chk tqp_chk_i (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .TIMER_OUTPUT_OUT(TIMER_OUTPUT_OUT));
